// ---- core/dcw_regs.vh ----
`ifndef DCW_REGS_VH
`define DCW_REGS_VH

// ==========================================================
// Register offsets
`define DCW_FUNC0_OFS  8'h18
`define DCW_FUNC1_OFS  8'h06
`define DCW_DATA0_OFS  8'h1c
`define DCW_DATA1_OFS  8'h19
`define DCW_TRIG_OFS   8'h20
`define DCW_MHI0_OFS   8'h0d
`define DCW_MLO0_OFS   8'h0e
`define DCW_MHI1_OFS   8'h01
`define DCW_MLO1_OFS   8'h02
`define DCW_BCAST_OFS  8'h22
`define DCW_GEN_OFS    8'h24
`define DCW_PM_PAGE0   8'h03
`define DCW_PM_PAGE1   8'h00
`define DCW_PM_PAGEC   8'hff
`define DCW_PM_DATA    8'h21
`define DCW_PM_FUNC0   8'he0
`define DCW_PM_FUNC1   8'hd4
`define DCW_PM_TRIG    8'he4

// ==========================================================
// Field positions and codes
`define DCW_CLRSEL_BIT 15
`define DCW_SYNC_BIT   14
`define DCW_BCAST_BIT  13
`define DCW_LOG_BIT    7
`define DCW_LOAD_BIT   7
`define DCW_CLR_BIT    6
`define DCW_SHAPE_TRI  3'h0
`define DCW_SHAPE_SAW  3'h1
`define DCW_SHAPE_INV  3'h2
`define DCW_SHAPE_SINE 3'h4
`define DCW_LOG_SHIFT  5

// ==========================================================
// Reset values and clear codes
`define DCW_FUNC_RST   16'h0000
`define DCW_DATA_RST   16'h0000
`define DCW_MARG_RST   16'h0000
`define DCW_ZERO_CODE  16'h0000
`define DCW_MID_CODE   16'h8000

// ==========================================================
// Step times in ns and their clock counts
`define DCW_CLK_MHZ    100
`define DCW_STEP_CW    20
`define DCW_NS2CYC(t)  ((t) * `DCW_CLK_MHZ / 1000)
`define DCW_STEP_TABLE ( \
  (`DCW_NS2CYC(4000) << 20) | (`DCW_NS2CYC(8000) << 40) | \
  (`DCW_NS2CYC(12000) << 60) | (`DCW_NS2CYC(18000) << 80) | \
  (`DCW_NS2CYC(27040) << 100) | (`DCW_NS2CYC(40480) << 120) | \
  (`DCW_NS2CYC(60720) << 140) | (`DCW_NS2CYC(91120) << 160) | \
  (`DCW_NS2CYC(136720) << 180) | (`DCW_NS2CYC(239200) << 200) | \
  (`DCW_NS2CYC(418640) << 220) | (`DCW_NS2CYC(732560) << 240) | \
  (`DCW_NS2CYC(1282000) << 260) | (`DCW_NS2CYC(2563960) << 280) | \
  (`DCW_NS2CYC(5127920) << 300))

`endif

// ---- core/dcw_step_timer.v ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Step interval timer
module dcw_step_timer #(
  parameter integer          CW    = 20,
  parameter [16*CW-1:0]      TABLE = {16*CW{1'b0}}
) (
  input  wire                clock,
  input  wire                sys_rst,
  input  wire                restart,
  input  wire [3:0]          sel,
  output wire                tick
);

  localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

  reg  [CW-1:0] count_q;
  wire [CW-1:0] lim = TABLE[sel*CW +: CW];

  assign tick = (sel != 4'h0) && (count_q >= lim - ONE);

  always @(posedge clock) begin
    if (sys_rst || restart || tick || sel == 4'h0) begin
      count_q <= {CW{1'b0}};
    end else begin
      count_q <= count_q + ONE;
    end
  end

endmodule // dcw_step_timer

`default_nettype wire

// ---- core/dcw_sine_rom.v ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Sine table, 64 points per period, registered read
module dcw_sine_rom (
  input  wire       clock,
  input  wire       sys_rst,
  input  wire [5:0] idx,
  output reg  [7:0] val
);

  function [7:0] quarter;
    input [4:0] k;
    begin
      case (k)
        5'd0:    quarter = 8'h00;
        5'd1:    quarter = 8'h0c;
        5'd2:    quarter = 8'h19;
        5'd3:    quarter = 8'h25;
        5'd4:    quarter = 8'h31;
        5'd5:    quarter = 8'h3c;
        5'd6:    quarter = 8'h47;
        5'd7:    quarter = 8'h51;
        5'd8:    quarter = 8'h5a;
        5'd9:    quarter = 8'h62;
        5'd10:   quarter = 8'h6a;
        5'd11:   quarter = 8'h70;
        5'd12:   quarter = 8'h75;
        5'd13:   quarter = 8'h7a;
        5'd14:   quarter = 8'h7d;
        5'd15:   quarter = 8'h7e;
        default: quarter = 8'h7f;
      endcase
    end
  endfunction

  wire [4:0] k_up = {1'b0, idx[3:0]};
  wire [4:0] k_dn = 5'h10 - k_up;

  always @(posedge clock) begin
    if (sys_rst) begin
      val <= 8'h80;
    end else begin
      case (idx[5:4])
        2'h0:    val <= 8'h80 + quarter(k_up);
        2'h1:    val <= 8'h80 + quarter(k_dn);
        2'h2:    val <= 8'h80 - quarter(k_up);
        default: val <= 8'h80 - quarter(k_dn);
      endcase
    end
  end

endmodule // dcw_sine_rom

`default_nettype wire

// ---- core/dcw_chan_ctrl.v ----
`timescale 1ns/1ps
`default_nettype none
`include "dcw_regs.vh"

// ==========================================================
// Two-channel update control and waveform generator
module dcw_chan_ctrl #(
  parameter integer                 RES      = 12,
  parameter integer                 STEP_CW  = `DCW_STEP_CW,
  parameter [16*STEP_CW-1:0]        STEP_CYC = `DCW_STEP_TABLE
) (
  input  wire                       clock,
  input  wire                       sys_rst,
  input  wire                       reg_wr,
  input  wire                       reg_rd,
  input  wire                       reg_pm,
  input  wire [7:0]                 pm_page,
  input  wire [7:0]                 reg_addr,
  input  wire [15:0]                reg_wdata,
  output reg  [15:0]                reg_rdata,
  output reg                        reg_rvalid,
  input  wire                       load_trigger_n,
  input  wire                       clear_trigger_n,
  output wire [RES-1:0]             chan0_code,
  output wire [RES-1:0]             chan1_code,
  output wire [1:0]                 gen_running
);

  localparam integer CW = 12;
  localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

  localparam [3:0] SEL_NONE  = 4'h0;
  localparam [3:0] SEL_FUNC0 = 4'h1;
  localparam [3:0] SEL_FUNC1 = 4'h2;
  localparam [3:0] SEL_DATA0 = 4'h3;
  localparam [3:0] SEL_DATA1 = 4'h4;
  localparam [3:0] SEL_MHI0  = 4'h5;
  localparam [3:0] SEL_MHI1  = 4'h6;
  localparam [3:0] SEL_MLO0  = 4'h7;
  localparam [3:0] SEL_MLO1  = 4'h8;
  localparam [3:0] SEL_TRIG  = 4'h9;
  localparam [3:0] SEL_BCAST = 4'ha;
  localparam [3:0] SEL_GEN   = 4'hb;

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_GEN  = 2'b10;

  // ==========================================================
  // Helper functions
  function [3:0] reg_sel;
    input       pm;
    input [7:0] page;
    input [7:0] a;
    begin
      reg_sel = SEL_NONE;
      if (!pm) begin
        case (a)
          `DCW_FUNC0_OFS: reg_sel = SEL_FUNC0;
          `DCW_FUNC1_OFS: reg_sel = SEL_FUNC1;
          `DCW_DATA0_OFS: reg_sel = SEL_DATA0;
          `DCW_DATA1_OFS: reg_sel = SEL_DATA1;
          `DCW_MHI0_OFS:  reg_sel = SEL_MHI0;
          `DCW_MHI1_OFS:  reg_sel = SEL_MHI1;
          `DCW_MLO0_OFS:  reg_sel = SEL_MLO0;
          `DCW_MLO1_OFS:  reg_sel = SEL_MLO1;
          `DCW_TRIG_OFS:  reg_sel = SEL_TRIG;
          `DCW_BCAST_OFS: reg_sel = SEL_BCAST;
          `DCW_GEN_OFS:   reg_sel = SEL_GEN;
          default:        reg_sel = SEL_NONE;
        endcase
      end else if (a == `DCW_PM_DATA && page == `DCW_PM_PAGE0) begin
        reg_sel = SEL_DATA0;
      end else if (a == `DCW_PM_DATA && page == `DCW_PM_PAGE1) begin
        reg_sel = SEL_DATA1;
      end else if (page == `DCW_PM_PAGEC) begin
        case (a)
          `DCW_PM_FUNC0: reg_sel = SEL_FUNC0;
          `DCW_PM_FUNC1: reg_sel = SEL_FUNC1;
          `DCW_PM_TRIG:  reg_sel = SEL_TRIG;
          default:       reg_sel = SEL_NONE;
        endcase
      end
    end
  endfunction

  function [CW-1:0] step_lsb;
    input [2:0] c;
    begin
      case (c)
        3'h0:    step_lsb = 12'h001;
        3'h1:    step_lsb = 12'h002;
        3'h2:    step_lsb = 12'h003;
        3'h3:    step_lsb = 12'h004;
        3'h4:    step_lsb = 12'h006;
        3'h5:    step_lsb = 12'h008;
        3'h6:    step_lsb = 12'h010;
        default: step_lsb = 12'h020;
      endcase
    end
  endfunction

  function [CW-1:0] toward;
    input [CW-1:0] cur;
    input [CW-1:0] lim;
    input [CW-1:0] st;
    begin
      if (cur < lim) begin
        toward = (lim - cur <= st) ? lim : cur + st;
      end else begin
        toward = (cur - lim <= st) ? lim : cur - st;
      end
    end
  endfunction

  function [8:0] start_pos;
    input [1:0] ph;
    input       is_tri;
    begin
      case ({is_tri, ph})
        3'b101:  start_pos = {1'b1, 8'd171};
        3'b110:  start_pos = {1'b0, 8'd171};
        3'b111:  start_pos = {1'b1, 8'd128};
        3'b001:  start_pos = {1'b1, 8'd85};
        3'b010:  start_pos = {1'b1, 8'd171};
        3'b011:  start_pos = {1'b1, 8'd64};
        default: start_pos = {1'b1, 8'd0};
      endcase
    end
  endfunction

  function [5:0] sine_phase;
    input [1:0] ph;
    begin
      case (ph)
        2'h1:    sine_phase = 6'd21;
        2'h2:    sine_phase = 6'd43;
        2'h3:    sine_phase = 6'd16;
        default: sine_phase = 6'd0;
      endcase
    end
  endfunction

  // ==========================================================
  // Register access decode
  wire [3:0] wsel = reg_wr ? reg_sel(reg_pm, pm_page, reg_addr) : SEL_NONE;
  wire [3:0] rsel = reg_sel(reg_pm, pm_page, reg_addr);

  wire sw_load  = (wsel == SEL_TRIG) && reg_wdata[`DCW_LOAD_BIT];
  wire sw_clr   = (wsel == SEL_TRIG) && reg_wdata[`DCW_CLR_BIT];
  wire bcast_wr = (wsel == SEL_BCAST);

  // ==========================================================
  // Pin synchronisers, bit 0 load and bit 1 clear
  reg  [1:0] pin_s0_q;
  reg  [1:0] pin_s1_q;
  reg  [1:0] pin_s2_q;
  reg  [1:0] pin_st_q;
  wire [1:0] pin_st_d = (pin_s1_q & pin_s2_q) | (pin_st_q & (pin_s1_q ^ pin_s2_q));
  wire [1:0] pin_fall = pin_st_q & ~pin_st_d;

  always @(posedge clock) begin
    if (sys_rst) begin
      pin_s0_q <= 2'h3;
      pin_s1_q <= 2'h3;
      pin_s2_q <= 2'h3;
      pin_st_q <= 2'h3;
    end else begin
      pin_s0_q <= {clear_trigger_n, load_trigger_n};
      pin_s1_q <= pin_s0_q;
      pin_s2_q <= pin_s1_q;
      pin_st_q <= pin_st_d;
    end
  end

  wire load_evt = sw_load | pin_fall[0];
  wire clr_evt  = sw_clr | pin_fall[1];

  // ==========================================================
  // Generator enable register
  reg [1:0] gen_q;

  always @(posedge clock) begin
    if (sys_rst) begin
      gen_q <= 2'h0;
    end else if (clr_evt) begin
      gen_q <= 2'h0;
    end else if (wsel == SEL_GEN) begin
      gen_q <= reg_wdata[1:0];
    end
  end

  // ==========================================================
  // Channels
  wire [15:0]   func_w [0:1];
  wire [15:0]   data_w [0:1];
  wire [15:0]   mhi_w  [0:1];
  wire [15:0]   mlo_w  [0:1];
  wire [CW-1:0] out_w  [0:1];

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ch
      localparam [3:0] S_FUNC = (i == 0) ? SEL_FUNC0 : SEL_FUNC1;
      localparam [3:0] S_DATA = (i == 0) ? SEL_DATA0 : SEL_DATA1;
      localparam [3:0] S_MHI  = (i == 0) ? SEL_MHI0 : SEL_MHI1;
      localparam [3:0] S_MLO  = (i == 0) ? SEL_MLO0 : SEL_MLO1;

      reg [15:0]   func_q;
      reg [15:0]   data_q;
      reg [15:0]   mhi_q;
      reg [15:0]   mlo_q;
      reg [CW-1:0] out_q;
      reg [CW-1:0] tgt_q;
      reg          dir_q;
      reg [5:0]    sidx_q;
      reg [1:0]    state_q;

      wire [2:0] shape  = func_q[10:8];
      wire [1:0] phase  = func_q[12:11];
      wire       log_m  = func_q[`DCW_LOG_BIT];
      wire [3:0] rate   = func_q[3:0];
      wire       sync_m = func_q[`DCW_SYNC_BIT];

      wire wr_data = (wsel == S_DATA);
      wire bc      = bcast_wr && func_q[`DCW_BCAST_BIT];
      wire upd     = ((wr_data | bc) & ~sync_m) | (load_evt & sync_m);
      wire [CW-1:0] new_code = (wr_data | bc) ? reg_wdata[15:4] : data_q[15:4];

      wire [CW-1:0] hi = mhi_q[15:4];
      wire [CW-1:0] lo = mlo_q[15:4];
      wire [CW-1:0] bottom = (lo == {CW{1'b0}}) ? ONE : lo;
      wire [15:0]   clr_code = func_q[`DCW_CLRSEL_BIT] ? `DCW_MID_CODE : `DCW_ZERO_CODE;

      wire shape_ok = (shape == `DCW_SHAPE_TRI) || (shape == `DCW_SHAPE_SAW) ||
                      (shape == `DCW_SHAPE_INV) || (shape == `DCW_SHAPE_SINE);
      wire gen_ok   = gen_q[i] && shape_ok && (log_m || rate != 4'h0);
      wire start    = gen_ok && state_q[0];

      wire [CW-1:0] lsh   = out_q >> `DCW_LOG_SHIFT;
      wire [CW-1:0] lstep = (lsh == {CW{1'b0}}) ? ONE : lsh;
      wire [CW-1:0] st    = log_m ? lstep : step_lsb(func_q[6:4]);
      wire [CW-1:0] floor = log_m ? bottom : lo;
      wire [CW-1:0] nx_up = toward(out_q, hi, st);
      wire [CW-1:0] nx_dn = toward(out_q, floor, st);

      wire [CW-1:0] span  = hi - lo;
      wire [8:0]    sp    = start_pos(phase, shape == `DCW_SHAPE_TRI);
      wire [CW+7:0] prod  = span * sp[7:0];
      wire [7:0]    sval;
      wire [CW+7:0] sprod = span * sval;

      wire [3:0] tsel = log_m ? (state_q[1] ? {(dir_q ? func_q[6:4] : func_q[3:1]), 1'b1} : 4'h0) : rate;
      wire       tick;

      dcw_step_timer #(
        .CW      (STEP_CW),
        .TABLE   (STEP_CYC)
      ) u_timer (
        .clock   (clock),
        .sys_rst (sys_rst),
        .restart (upd | start | clr_evt),
        .sel     (tsel),
        .tick    (tick)
      );

      dcw_sine_rom u_sine (
        .clock   (clock),
        .sys_rst (sys_rst),
        .idx     (sidx_q),
        .val     (sval)
      );

      always @(posedge clock) begin
        if (sys_rst) begin
          func_q  <= `DCW_FUNC_RST;
          data_q  <= `DCW_DATA_RST;
          mhi_q   <= `DCW_MARG_RST;
          mlo_q   <= `DCW_MARG_RST;
          out_q   <= {CW{1'b0}};
          tgt_q   <= {CW{1'b0}};
          dir_q   <= 1'b1;
          sidx_q  <= 6'h0;
          state_q <= ST_IDLE;
        end else begin
          if (wsel == S_FUNC) begin
            func_q <= reg_wdata;
          end
          if (wsel == S_MHI) begin
            mhi_q <= reg_wdata;
          end
          if (wsel == S_MLO) begin
            mlo_q <= reg_wdata;
          end
          if (wr_data || bc) begin
            data_q <= reg_wdata;
          end
          case (state_q)
            ST_IDLE: begin
              if (start) begin
                state_q <= ST_GEN;
                if (log_m) begin
                  out_q <= bottom;
                  dir_q <= 1'b1;
                end else begin
                  out_q  <= (shape == `DCW_SHAPE_INV) ? hi - prod[CW+7:8] : lo + prod[CW+7:8];
                  dir_q  <= sp[8];
                  sidx_q <= sine_phase(phase);
                end
              end else if (upd) begin
                tgt_q <= new_code;
                if (log_m || rate == 4'h0) begin
                  out_q <= new_code;
                end
              end else if (tick) begin
                out_q <= toward(out_q, tgt_q, st);
              end
            end
            ST_GEN: begin
              if (!gen_ok) begin
                state_q <= ST_IDLE;
                tgt_q   <= out_q;
              end else if (!log_m && shape == `DCW_SHAPE_SINE) begin
                out_q <= lo + sprod[CW+7:8];
                if (tick) begin
                  sidx_q <= sidx_q + 6'h1;
                end
              end else if (tick) begin
                if (!log_m && shape == `DCW_SHAPE_SAW) begin
                  out_q <= (out_q == hi) ? lo : nx_up;
                end else if (!log_m && shape == `DCW_SHAPE_INV) begin
                  out_q <= (out_q == lo) ? hi : nx_dn;
                end else if (dir_q) begin
                  out_q <= nx_up;
                  if (nx_up == hi) begin
                    dir_q <= 1'b0;
                  end
                end else begin
                  out_q <= nx_dn;
                  if (nx_dn == floor) begin
                    dir_q <= 1'b1;
                  end
                end
              end
            end
            default: begin
              state_q <= ST_IDLE;
            end
          endcase
          if (clr_evt) begin
            data_q  <= clr_code;
            out_q   <= clr_code[15:4];
            tgt_q   <= clr_code[15:4];
            state_q <= ST_IDLE;
          end
        end
      end

      assign func_w[i]      = func_q;
      assign data_w[i]      = data_q;
      assign mhi_w[i]       = mhi_q;
      assign mlo_w[i]       = mlo_q;
      assign out_w[i]       = out_q;
      assign gen_running[i] = state_q[1];
    end
  endgenerate

  assign chan0_code = out_w[0][CW-1 -: RES];
  assign chan1_code = out_w[1][CW-1 -: RES];

  // ==========================================================
  // Read path
  reg [15:0] rd_mux;

  always @* begin
    case (rsel)
      SEL_FUNC0: rd_mux = func_w[0];
      SEL_FUNC1: rd_mux = func_w[1];
      SEL_DATA0: rd_mux = data_w[0];
      SEL_DATA1: rd_mux = data_w[1];
      SEL_MHI0:  rd_mux = mhi_w[0];
      SEL_MHI1:  rd_mux = mhi_w[1];
      SEL_MLO0:  rd_mux = mlo_w[0];
      SEL_MLO1:  rd_mux = mlo_w[1];
      SEL_GEN:   rd_mux = {12'h000, gen_running, gen_q};
      default:   rd_mux = 16'h0000;
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule // dcw_chan_ctrl

`default_nettype wire

// ---- test/dcw_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host side of the register bus and the two trigger pins
module dcw_host_model (
  input  wire logic        clock,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  output var  logic        reg_pm,
  output var  logic [7:0]  pm_page,
  output var  logic [7:0]  reg_addr,
  output var  logic [15:0] reg_wdata,
  output var  logic        load_trigger_n,
  output var  logic        clear_trigger_n
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_pm = 1'b0;
    pm_page = 8'h00;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    load_trigger_n = 1'b1;
    clear_trigger_n = 1'b1;
  end

  // Idle page, address and data lines show the inverse of the last value; reg_pm keeps its last value.
  task automatic drop(input logic [7:0] pg, input logic [7:0] a, input logic [15:0] d);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    pm_page <= ~pg;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic wr(input logic pm, input logic [7:0] pg, input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_pm <= pm;
    pm_page <= pg;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    drop(pg, a, d);
  endtask

  task automatic rd(input logic pm, input logic [7:0] pg, input logic [7:0] a,
                    output logic [15:0] d, output logic ok);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_pm <= pm;
    pm_page <= pg;
    reg_addr <= a;
    @(posedge clock);
    drop(pg, a, reg_wdata);
    @(negedge clock);
    ok = reg_rvalid;
    d = reg_rdata;
  endtask

  task automatic pulse(input logic clr);
    @(posedge clock);
    if (clr) clear_trigger_n <= 1'b0;
    else load_trigger_n <= 1'b0;
    repeat (6) @(posedge clock);
    clear_trigger_n <= 1'b1;
    load_trigger_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
endmodule // dcw_host_model

`default_nettype wire

// ---- test/dcw_chan_ctrl_props.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Port checker
module dcw_chan_ctrl_props #(
  parameter integer RES = 12
) (
  input wire logic           clock,
  input wire logic           sys_rst,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic           reg_pm,
  input wire logic [7:0]     pm_page,
  input wire logic [7:0]     reg_addr,
  input wire logic [15:0]    reg_wdata,
  input wire logic [15:0]    reg_rdata,
  input wire logic           reg_rvalid,
  input wire logic           load_trigger_n,
  input wire logic           clear_trigger_n,
  input wire logic [RES-1:0] chan0_code,
  input wire logic [RES-1:0] chan1_code,
  input wire logic [1:0]     gen_running
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_trig_clear;
    reg_wr && !reg_pm && reg_addr == 8'h20 && reg_wdata[6];
  endsequence
  sequence s_trig_rd;
    reg_rd && !reg_pm && reg_addr == 8'h20;
  endsequence

  a_rd_gets_valid: assert property (reg_rd |=> reg_rvalid) else $error("read without valid");
  a_valid_from_rd: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray valid");
  a_rdata_held: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
  a_trig_reads_zero: assert property (s_trig_rd |=> reg_rdata == 16'h0000) else $error("trigger stored");
  a_clear_stops_gen: assert property (s_trig_clear |-> ##[1:2] gen_running == 2'b00)
    else $error("clear left generator on");
  a_clear_no_valid: assert property (s_trig_clear ##1 !reg_rd |=> !reg_rvalid) else $error("valid on write");
  a_reset_codes: assert property (disable iff (1'b0) sys_rst |=> chan0_code == '0 && chan1_code == '0)
    else $error("codes not zero in reset");
  a_reset_outputs: assert property (disable iff (1'b0) sys_rst |=> gen_running == 2'b00 && !reg_rvalid)
    else $error("outputs active in reset");
endmodule // dcw_chan_ctrl_props

`default_nettype wire

// ---- test/dac_channel_update_and_waveform_gen_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module dac_channel_update_and_waveform_gen_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr, reg_rd, reg_pm, reg_rvalid, load_trigger_n, clear_trigger_n, ok;
  logic [7:0] pm_page, reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [11:0] chan0_code, chan1_code;
  logic [1:0] gen_running;
  integer num_errors = 0;
  integer tests_run = 0;
  integer i;

  always #5 clock = ~clock;

  dcw_host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_pm(reg_pm), .pm_page(pm_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .load_trigger_n(load_trigger_n), .clear_trigger_n(clear_trigger_n));

  // Every step interval shortened to four clocks.
  dcw_chan_ctrl #(.RES(12), .STEP_CYC({16{20'd4}})) dut (.clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_pm(reg_pm), .pm_page(pm_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .load_trigger_n(load_trigger_n),
    .clear_trigger_n(clear_trigger_n), .chan0_code(chan0_code), .chan1_code(chan1_code),
    .gen_running(gen_running));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdc(input logic pm, input logic [7:0] pg, input logic [7:0] a, input logic [15:0] exp);
    host.rd(pm, pg, a, d, ok);
    chk("read valid", 16'h0001, {15'h0000, ok});
    chk("read data", exp, d & 16'hfff0);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic t_update;
    host.wr(1'b0, 8'h00, 8'h18, 16'h0000);
    host.wr(1'b0, 8'h00, 8'h1c, 16'habc5);
    @(negedge clock);
    chk("chan0 immediate", 16'h0abc, {4'h0, chan0_code});
    host.wr(1'b1, 8'h00, 8'h21, 16'h1230);
    @(negedge clock);
    chk("chan1 paged", 16'h0123, {4'h0, chan1_code});
    rdc(1'b1, 8'h03, 8'h21, 16'habc0);
    rdc(1'b0, 8'h00, 8'h3f, 16'h0000);
    $display("update test done");
  endtask

  task automatic t_sync;
    host.wr(1'b0, 8'h00, 8'h06, 16'h4000);
    host.wr(1'b0, 8'h00, 8'h19, 16'h4560);
    repeat (3) @(negedge clock);
    chk("chan1 deferred", 16'h0123, {4'h0, chan1_code});
    host.wr(1'b0, 8'h00, 8'h20, 16'h0080);
    repeat (3) @(negedge clock);
    chk("chan1 soft load", 16'h0456, {4'h0, chan1_code});
    rdc(1'b0, 8'h00, 8'h20, 16'h0000);
    host.wr(1'b0, 8'h00, 8'h19, 16'h7890);
    host.pulse(1'b0);
    chk("chan1 pin load", 16'h0789, {4'h0, chan1_code});
    $display("sync test done");
  endtask

  task automatic t_bcast;
    host.wr(1'b0, 8'h00, 8'h18, 16'h2000);
    host.wr(1'b0, 8'h00, 8'h06, 16'h0000);
    host.wr(1'b0, 8'h00, 8'h22, 16'h5550);
    repeat (2) @(negedge clock);
    chk("chan0 broadcast", 16'h0555, {4'h0, chan0_code});
    chk("chan1 ignores", 16'h0789, {4'h0, chan1_code});
    $display("broadcast test done");
  endtask

  task automatic t_clear;
    host.wr(1'b0, 8'h00, 8'h18, 16'h8000);
    host.wr(1'b0, 8'h00, 8'h20, 16'h0040);
    repeat (2) @(negedge clock);
    chk("chan0 mid", 16'h0800, {4'h0, chan0_code});
    chk("chan1 zero", 16'h0000, {4'h0, chan1_code});
    rdc(1'b0, 8'h00, 8'h1c, 16'h8000);
    host.wr(1'b0, 8'h00, 8'h06, 16'h8000);
    host.pulse(1'b1);
    chk("chan1 pin clear", 16'h0800, {4'h0, chan1_code});
    $display("clear test done");
  endtask

  task automatic t_gen;
    host.wr(1'b0, 8'h00, 8'h18, 16'h0001);
    host.wr(1'b0, 8'h00, 8'h24, 16'h0001);
    repeat (2) @(negedge clock);
    chk("gen running", 16'h0001, {14'h0000, gen_running});
    host.wr(1'b0, 8'h00, 8'h20, 16'h0040);
    repeat (2) @(negedge clock);
    chk("gen cleared", 16'h0000, {14'h0000, gen_running});
    host.wr(1'b0, 8'h00, 8'h18, 16'h0701);
    host.wr(1'b0, 8'h00, 8'h24, 16'h0001);
    repeat (2) @(negedge clock);
    chk("gen disabled", 16'h0000, {14'h0000, gen_running});
    host.wr(1'b0, 8'h00, 8'h24, 16'h0000);
    $display("generator test done");
  endtask

  task automatic t_slew;
    host.wr(1'b0, 8'h00, 8'h18, 16'h0000);
    host.wr(1'b0, 8'h00, 8'h1c, 16'h0000);
    host.wr(1'b0, 8'h00, 8'h18, 16'h0011);
    host.wr(1'b0, 8'h00, 8'h1c, 16'h0070);
    repeat (8) @(negedge clock);
    chk("slew not done", 16'h0001, {15'h0000, chan0_code < 12'h007});
    chk("slew step", 16'h0002, {4'h0, chan0_code});
    for (i = 0; i < 30; i = i + 1) begin
      @(negedge clock);
      if (chan0_code > 12'h007) chk("overshoot", 16'h0007, {4'h0, chan0_code});
    end
    chk("slew end", 16'h0007, {4'h0, chan0_code});
    $display("slew test done");
  endtask

  task automatic t_log;
    host.wr(1'b0, 8'h00, 8'h0d, 16'h0c00);
    host.wr(1'b0, 8'h00, 8'h0e, 16'h0000);
    host.wr(1'b0, 8'h00, 8'h18, 16'h0080);
    host.wr(1'b0, 8'h00, 8'h24, 16'h0001);
    repeat (2) @(negedge clock);
    chk("log start", 16'h0001, {4'h0, chan0_code});
    host.wr(1'b0, 8'h00, 8'h24, 16'h0000);
    host.wr(1'b0, 8'h00, 8'h18, 16'h0901);
    host.wr(1'b0, 8'h00, 8'h24, 16'h0001);
    repeat (2) @(negedge clock);
    chk("saw phase", 16'h0001, {15'h0000, chan0_code >= 12'h03f && chan0_code <= 12'h040});
    host.wr(1'b0, 8'h00, 8'h24, 16'h0000);
    $display("log and phase test done");
  endtask

  initial begin
    #200000;
    num_errors = num_errors + 1;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    chk("reset codes", 16'h0000, {chan0_code[11:4], chan1_code[11:4]});
    rdc(1'b0, 8'h00, 8'h19, 16'h0000);
    t_update();
    t_sync();
    t_bcast();
    t_clear();
    t_gen();
    t_slew();
    t_log();
    finish_test();
  end
endmodule // dac_channel_update_and_waveform_gen_tb

bind dcw_chan_ctrl dcw_chan_ctrl_props #(.RES(RES)) u_props (.clock(clock), .sys_rst(sys_rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_pm(reg_pm), .pm_page(pm_page), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .load_trigger_n(load_trigger_n),
  .clear_trigger_n(clear_trigger_n), .chan0_code(chan0_code), .chan1_code(chan1_code),
  .gen_running(gen_running));

`default_nettype wire
